//--- logic/hpr_host.sv
`timescale 1ns/1ps
`default_nettype none
module hpr_host #(
   parameter logic [31:0] P_PGM_CYC = 32'(hpr_pkg::PGM_CYC),
   parameter logic [31:0] P_EXIT_CYC = 32'(hpr_pkg::PGM_EXIT_CYC),
   parameter logic [31:0] P_PST_CYC = 32'(hpr_pkg::PGMPST_CYC)
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic [1:0] i_bg,
   input wire logic [1:0] i_ba,
   input wire logic [17:0] i_row,
   input wire logic [17:0] i_mr0_saved,
   input wire logic [5:0] i_wl,
   input wire logic i_ref_req,
   output logic o_busy,
   output logic o_done,
   output hpr_pkg::hpr_cmd_t o_cmd,
   output logic [1:0] o_bg,
   output logic [1:0] o_ba,
   output logic [17:0] o_addr,
   output logic o_dq_oe,
   output logic o_dq,
   output logic o_dqs_oe,
   output logic o_dqs,
   output logic o_ref_ok
);
   import hpr_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ENTER, ST_KEY, ST_ACT, ST_WRA, ST_WAITWL, ST_BURST,
      ST_PGM, ST_PRE, ST_RECOG, ST_EXIT, ST_POST, ST_MR0, ST_FIN
   } hpr_state_t;

   typedef struct packed {
      hpr_state_t st;
      logic [31:0] cnt;
      logic [31:0] since_wra;
      logic [31:0] ref_gap;
      logic ref_ok;
      logic [1:0] key;
      hpr_cmd_t cmd;
      logic [1:0] bg;
      logic [1:0] ba;
      logic [17:0] addr;
      logic dq_oe;
      logic dqs;
      logic done;
   } hpr_regs_t;

   hpr_regs_t state_ff;
   hpr_regs_t nxt_state;

   // Guard key value for each step of the key walk.
   function automatic logic [4:0] key_of(input logic [1:0] k);
      unique case (k)
         2'h0: key_of = GUARD_KEY0;
         2'h1: key_of = GUARD_KEY1;
         2'h2: key_of = GUARD_KEY2;
         2'h3: key_of = GUARD_KEY3;
      endcase
   endfunction : key_of

   // A mode register number rides on the low bank-group bit and both bank bits, so MR4
   // needs a bank group of one; putting it on the bank bits alone would hit MR0.
   function automatic logic [3:0] mr_sel(input int num);
      mr_sel = 4'(num);
   endfunction : mr_sel

   // Sequencer; commands and counters advance together, at most one command per clock.
   always_comb begin
      logic [31:0] wl_done;
      wl_done = 32'(i_wl) + 32'(BURST_CLOCKS) + 32'(T_WR_CYC) + 32'(T_RP_CYC);
      nxt_state = state_ff;
      nxt_state.cmd = HPR_CMD_DES;
      nxt_state.done = 1'b0;
      nxt_state.cnt = (state_ff.cnt != 32'h0) ? state_ff.cnt - 32'h1 : 32'h0;
      nxt_state.ref_gap = (state_ff.ref_gap != 32'h0) ? state_ff.ref_gap - 32'h1 : 32'h0;
      if (state_ff.since_wra != 32'hFFFFFFFF) begin
         nxt_state.since_wra = state_ff.since_wra + 32'h1;
      end
      // Refresh is opened only after the write's recovery and precharge.
      nxt_state.ref_ok = (state_ff.st inside {ST_PGM, ST_PRE, ST_RECOG})
                         && (state_ff.since_wra >= wl_done);
      nxt_state.dqs = state_ff.dq_oe ? ~state_ff.dqs : 1'b0;
      unique case (state_ff.st)
         ST_IDLE: begin
            nxt_state.dq_oe = 1'b0;
            if (i_start) begin
               // The caller guarantees banks idle and DBI/CRC off on start.
               nxt_state.cmd = HPR_CMD_MRS;
               {nxt_state.bg, nxt_state.ba} = mr_sel(MR4_ADDR);
               nxt_state.addr = 18'h0;
               nxt_state.addr[MR4_REPAIR_BIT] = 1'b1;
               nxt_state.cnt = 32'(T_MOD_CYC);
               nxt_state.key = 2'h0;
               nxt_state.st = ST_ENTER;
            end
         end
         ST_ENTER, ST_KEY: begin
            if (state_ff.cnt == 32'h0) begin
               // Keys go out back to back at mode-set spacing, nothing between.
               nxt_state.cmd = HPR_CMD_MRS;
               {nxt_state.bg, nxt_state.ba} = mr_sel(MR0_ADDR);
               nxt_state.addr = KEY_LOW_ONES;
               nxt_state.addr[KEY_LSB +: 5] = key_of(state_ff.key);
               nxt_state.cnt = 32'(T_MOD_CYC);
               nxt_state.key = state_ff.key + 2'h1;
               nxt_state.st = (state_ff.key == 2'h3) ? ST_ACT : ST_KEY;
            end
         end
         ST_ACT: begin
            if (state_ff.cnt == 32'h0) begin
               nxt_state.cmd = HPR_CMD_ACT;
               nxt_state.bg = i_bg;
               nxt_state.ba = i_ba;
               nxt_state.addr = i_row;
               nxt_state.cnt = 32'(T_RCD_CYC);
               nxt_state.st = ST_WRA;
            end
         end
         ST_WRA: begin
            if (state_ff.cnt == 32'h0) begin
               // Column lines held at zero; the device ignores them.
               nxt_state.cmd = HPR_CMD_WRA;
               nxt_state.addr = 18'h0;
               nxt_state.since_wra = 32'h0;
               nxt_state.cnt = 32'(i_wl);
               nxt_state.st = ST_WAITWL;
            end
         end
         // The counter was loaded with WL at the write, so the burst opens WL clocks later.
         ST_WAITWL: begin
            if (state_ff.cnt <= 32'h1) begin
               nxt_state.dq_oe = 1'b1;
               nxt_state.cnt = 32'(BURST_CLOCKS);
               nxt_state.st = ST_BURST;
            end
         end
         // Four clocks of low data carry all eight beats of the repair pattern.
         ST_BURST: begin
            if (state_ff.cnt <= 32'h1) begin
               nxt_state.dq_oe = 1'b0;
               nxt_state.cnt = P_PGM_CYC;
               nxt_state.st = ST_PGM;
            end
         end
         // Refresh goes out only here; it keeps the other banks alive during the long burn.
         ST_PGM: begin
            if (state_ff.cnt == 32'h0) begin
               nxt_state.st = ST_PRE;
            end else if (state_ff.ref_ok && i_ref_req && state_ff.ref_gap == 32'h0) begin
               nxt_state.cmd = HPR_CMD_REF;
               nxt_state.ref_gap = 32'(T_REF_GAP_CYC);
            end
         end
         // Single-bank precharge of the target closes the programming wait.
         ST_PRE: begin
            nxt_state.cmd = HPR_CMD_PRE;
            nxt_state.bg = i_bg;
            nxt_state.ba = i_ba;
            nxt_state.cnt = P_EXIT_CYC;
            nxt_state.st = ST_RECOG;
         end
         // Repair bit cleared with an all-zero address once the device has taken the row.
         ST_RECOG: begin
            if (state_ff.cnt == 32'h0) begin
               nxt_state.cmd = HPR_CMD_MRS;
               {nxt_state.bg, nxt_state.ba} = mr_sel(MR4_ADDR);
               nxt_state.addr = 18'h0;
               nxt_state.cnt = P_PST_CYC;
               nxt_state.st = ST_POST;
            end
         end
         ST_POST: begin
            if (state_ff.cnt == 32'h0) begin
               nxt_state.cmd = HPR_CMD_MRS;
               {nxt_state.bg, nxt_state.ba} = mr_sel(MR0_ADDR);
               nxt_state.addr = i_mr0_saved;
               nxt_state.cnt = 32'(T_MOD_CYC);
               nxt_state.st = ST_FIN;
            end
         end
         ST_FIN: begin
            if (state_ff.cnt == 32'h0) begin
               // Back to idle so another row can be fixed with a new start.
               nxt_state.done = 1'b1;
               nxt_state.since_wra = 32'hFFFFFFFF;
               nxt_state.st = ST_IDLE;
            end
         end
         default: nxt_state.st = ST_IDLE;
      endcase
   end

   // State register; the clock enable freezes everything.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_ff <= '{st: ST_IDLE, cnt: 32'h0, since_wra: 32'hFFFFFFFF, ref_gap: 32'h0,
                       ref_ok: 1'b0, key: 2'h0, cmd: HPR_CMD_DES, bg: 2'h0, ba: 2'h0,
                       addr: 18'h0, dq_oe: 1'b0, dqs: 1'b0, done: 1'b0};
      end else if (i_ce) begin
         state_ff <= nxt_state;
      end
   end

   assign o_busy = (state_ff.st != ST_IDLE);
   assign o_done = state_ff.done; // Caller may then write and read back the row.
   assign o_cmd = state_ff.cmd;
   assign o_bg = state_ff.bg;
   assign o_ba = state_ff.ba;
   assign o_addr = state_ff.addr;
   assign o_dq_oe = state_ff.dq_oe;
   assign o_dq = 1'b0; // All DQ low while driven, so the repair proceeds.
   assign o_dqs_oe = state_ff.dq_oe;
   assign o_dqs = state_ff.dqs;
   assign o_ref_ok = state_ff.ref_ok;
endmodule : hpr_host
`default_nettype wire

//--- logic/hpr_pkg.sv
// How it works
// - Precharge all (left to the caller), then set repair mode bit.
// - Four guard keys to MR0, mode-set spaced.
// - Activate failing bank group, bank, row.
// - Write with auto-precharge; column value ignored.
// - Drive all DQ low four clocks after WL.
// - Data strobe toggles normally during burst.
// - Refresh only after WL+4+write recovery+precharge.
// - Refresh spacing at least quarter refresh interval.
// - Precharge only after repair programming time.
// - Wait recognition time after that precharge.
// - Clear repair bit, wait PGMPST time.
// - Whole sequence may repeat per row.
// - Restore MR0 before normal access.
// - Optional write and read-back check.
package hpr_pkg;
   // Command encodings placed on o_cmd, decoded by the pin driver outside.
   typedef enum logic [2:0] {
      HPR_CMD_DES = 3'h0,
      HPR_CMD_MRS = 3'h1,
      HPR_CMD_ACT = 3'h2,
      HPR_CMD_WRA = 3'h3,
      HPR_CMD_PRE = 3'h4,
      HPR_CMD_REF = 3'h5
   } hpr_cmd_t;

   localparam int CLK_PERIOD_PS = 8000;
   localparam int MR4_ADDR = 4;
   localparam int MR0_ADDR = 0;
   localparam int MR4_REPAIR_BIT = 13;
   localparam int KEY_LSB = 7;
   localparam logic [17:0] KEY_LOW_ONES = 18'h0007F;
   localparam logic [4:0] GUARD_KEY0 = 5'h19;
   localparam logic [4:0] GUARD_KEY1 = 5'h0F;
   localparam logic [4:0] GUARD_KEY2 = 5'h17;
   localparam logic [4:0] GUARD_KEY3 = 5'h07;
   localparam int BURST_CLOCKS = 4;
   // Times in nanoseconds; least-time counts round up, but T_REFI_CYC rounds down.
   localparam int T_MOD_NS = 30;
   localparam int T_RCD_NS = 15;
   localparam int T_WR_NS = 15;
   localparam int T_RP_NS = 15;
   localparam int T_REFI_NS = 7800;
   localparam int T_MOD_CYC = (T_MOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_RCD_CYC = (T_RCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_WR_CYC = (T_WR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_RP_CYC = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_REFI_CYC = (T_REFI_NS * 1000) / CLK_PERIOD_PS;
   localparam int T_REF_GAP_CYC = (T_REFI_CYC + 3) / 4;
   // Long times in milliseconds and microseconds, defaults of top-level parameters.
   localparam int PGM_MS = 1000;
   localparam int PGM_EXIT_US = 15;
   localparam int PGMPST_US = 50;
   localparam int PGM_CYC = PGM_MS * 125000;
   localparam int PGM_EXIT_CYC = PGM_EXIT_US * 125;
   localparam int PGMPST_CYC = PGMPST_US * 125;
   localparam int CNT_W = 32;
endpackage : hpr_pkg

//--- verification/hpr_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module hpr_dev_model import hpr_pkg::*; (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire hpr_pkg::hpr_cmd_t i_cmd,
   input wire logic [1:0] i_bg,
   input wire logic [1:0] i_ba,
   input wire logic [17:0] i_addr,
   input wire logic i_dq_oe,
   input wire logic i_dq,
   output logic o_fixed,
   output logic [21:0] o_target,
   output logic [7:0] o_refs
);
   localparam logic [19:0] KEYS = {GUARD_KEY3, GUARD_KEY2, GUARD_KEY1, GUARD_KEY0};
   logic mode_ff;
   logic bad_ff;
   logic [2:0] key_ff;
   logic [2:0] beat_ff;
   // Device side of the repair; keys out of order simply restart, so repair stays disarmed.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         {mode_ff, bad_ff, key_ff, beat_ff, o_fixed, o_refs} <= '0;
      end else begin
         if (i_cmd == HPR_CMD_MRS && {i_bg, i_ba} == 4'(MR4_ADDR)) begin
            mode_ff <= i_addr[MR4_REPAIR_BIT];
            key_ff <= 3'h0;
         end
         if (i_cmd == HPR_CMD_MRS && {i_bg, i_ba} == 4'(MR0_ADDR) && mode_ff && key_ff < 3'h4) begin
            key_ff <= (i_addr[11:7] == KEYS[5*key_ff +: 5]) ? key_ff + 3'h1 : 3'h0;
         end
         if (i_cmd == HPR_CMD_ACT && key_ff == 3'h4) begin
            o_target <= {i_bg, i_ba, i_addr};
            {o_fixed, bad_ff, beat_ff} <= '0;
         end
         // One sample per clock stands for its two beats on every lane.
         if (i_dq_oe && key_ff == 3'h4) begin
            beat_ff <= beat_ff + 3'h1;
            bad_ff <= bad_ff | i_dq;
         end
         if (!i_dq_oe && beat_ff == 3'h4) begin
            o_fixed <= !bad_ff;
            beat_ff <= 3'h0;
         end
         // The bank under repair is skipped, so only the count is kept.
         if (i_cmd == HPR_CMD_REF) begin
            o_refs <= o_refs + 8'h01;
         end
      end
   end
endmodule : hpr_dev_model
`default_nettype wire

//--- verification/hpr_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hpr_host_chk import hpr_pkg::*; (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic [5:0] i_wl,
   input wire logic o_busy,
   input wire hpr_pkg::hpr_cmd_t o_cmd,
   input wire logic [1:0] o_bg,
   input wire logic [1:0] o_ba,
   input wire logic [17:0] o_addr,
   input wire logic o_dq_oe,
   input wire logic o_dq,
   input wire logic o_dqs_oe,
   input wire logic o_dqs,
   input wire logic o_ref_ok
);
   logic [15:0] wra_ff;
   logic [15:0] ref_ff;
   // Cycles since the last write and refresh; they stick at the top so idle time never wraps.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         wra_ff <= 16'hFFFF;
         ref_ff <= 16'hFFFF;
      end else begin
         wra_ff <= (o_cmd == HPR_CMD_WRA) ? 16'h0001 : wra_ff + 16'(wra_ff != 16'hFFFF);
         ref_ff <= (o_cmd == HPR_CMD_REF) ? 16'h0001 : ref_ff + 16'(ref_ff != 16'hFFFF);
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   property p_dq_low; o_dq_oe |-> o_dq == 1'b0; endproperty
   a_dq_low: assert property (p_dq_low) else $error("data driven high in burst");
   property p_burst; $rose(o_dq_oe) |-> o_dq_oe[*4] ##1 !o_dq_oe; endproperty
   a_burst: assert property (p_burst) else $error("burst not four clocks");
   property p_wl; o_cmd == HPR_CMD_WRA |-> ##[1:70] $rose(o_dq_oe); endproperty
   a_wl: assert property (p_wl) else $error("no burst after write");
   property p_dqs; o_dqs_oe && $past(o_dqs_oe) |-> o_dq_oe && o_dqs != $past(o_dqs); endproperty
   a_dqs: assert property (p_dqs) else $error("strobe not toggling");
   property p_ref_win; o_cmd == HPR_CMD_REF |-> wra_ff >= 16'(i_wl) + 16'(4 + T_WR_CYC + T_RP_CYC);
   endproperty
   a_ref_win: assert property (p_ref_win) else $error("refresh too early");
   property p_ref_ok; o_ref_ok |-> wra_ff >= 16'(i_wl) + 16'(4 + T_WR_CYC + T_RP_CYC);
   endproperty
   a_ref_ok: assert property (p_ref_ok) else $error("refresh window open too early");
   property p_ref_gap; o_cmd == HPR_CMD_REF |-> ref_ff >= 16'(T_REF_GAP_CYC); endproperty
   a_ref_gap: assert property (p_ref_gap) else $error("refreshes too close");
   property p_start; i_ce && i_start && !o_busy |=> o_cmd == HPR_CMD_MRS
      && {o_bg, o_ba} == 4'(MR4_ADDR) && o_addr[MR4_REPAIR_BIT]; endproperty
   a_start: assert property (p_start) else $error("no mode set after start");
   property p_key0; o_cmd == HPR_CMD_MRS && {o_bg, o_ba} == 4'(MR4_ADDR) && o_addr[MR4_REPAIR_BIT]
      |=> (o_cmd == HPR_CMD_DES)[*3] ##[1:3] (o_cmd == HPR_CMD_MRS
      && {o_bg, o_ba} == 4'(MR0_ADDR)
      && o_addr[11:7] == GUARD_KEY0 && o_addr[6:0] == 7'h7F); endproperty
   a_key0: assert property (p_key0) else $error("first key wrong");
endmodule : hpr_host_chk
bind hpr_host hpr_host_chk u_chk (.*);
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import hpr_pkg::*;
   localparam int PGM = 600;
   localparam int EXT = 10;
   localparam int PST = 10;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_start = 1'b0;
   logic i_ref_req = 1'b0;
   logic [21:0] tgt = '0;
   logic [17:0] mr0 = 18'h00A5C;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   int t_wra, t_pre, t_clr, t_mr0, n_set;
   logic busy, done, dq_oe, dq, dqs_oe, dqs, fixed;
   hpr_cmd_t cmd;
   logic [1:0] bg, ba;
   logic [17:0] addr;
   logic [21:0] seen;
   logic [7:0] refs;
   always #4 i_clk = ~i_clk;
   hpr_host #(.P_PGM_CYC(32'(PGM)), .P_EXIT_CYC(32'(EXT)), .P_PST_CYC(32'(PST))) dut (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .i_start(i_start), .i_bg(tgt[21:20]),
      .i_ba(tgt[19:18]), .i_row(tgt[17:0]), .i_mr0_saved(mr0), .i_wl(6'h05),
      .i_ref_req(i_ref_req), .o_busy(busy), .o_done(done), .o_cmd(cmd), .o_bg(bg), .o_ba(ba),
      .o_addr(addr), .o_dq_oe(dq_oe), .o_dq(dq), .o_dqs_oe(dqs_oe), .o_dqs(dqs), .o_ref_ok());
   hpr_dev_model u_dev (.i_clk(i_clk), .i_resetn(i_resetn), .i_cmd(cmd), .i_bg(bg), .i_ba(ba),
      .i_addr(addr), .i_dq_oe(dq_oe), .i_dq(dq), .o_fixed(fixed), .o_target(seen), .o_refs(refs));
   // Stamp commands by cycle so the long waits can be judged after the run.
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cmd == HPR_CMD_WRA) t_wra <= cyc;
      if (cmd == HPR_CMD_PRE) t_pre <= cyc;
      if (cmd == HPR_CMD_MRS && {bg, ba} == 4'(MR0_ADDR) && addr === mr0) t_mr0 <= cyc;
      if (cmd == HPR_CMD_MRS && {bg, ba} == 4'(MR4_ADDR)) begin
         if (addr[MR4_REPAIR_BIT]) n_set <= n_set + 1;
         else t_clr <= cyc;
      end
   end
   task chk(input logic c, input string m);
      checked++;
      if (c !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk
   // A second start mid-run must be ignored, so only one repair-bit mode set may appear.
   task run_repair(input logic [21:0] t, input logic rq);
      int n0;
      @(negedge i_clk);
      n0 = n_set;
      {tgt, i_ref_req, i_start} = {t, rq, 1'b1};
      @(negedge i_clk);
      i_start = 1'b0;
      repeat (10) @(negedge i_clk);
      i_start = 1'b1;
      @(negedge i_clk);
      i_start = 1'b0;
      for (int k = 0; k < 2000 && done !== 1'b1; k++) @(negedge i_clk);
      chk(done, "no done");
      chk(n_set - n0 == 1, "start not refused");
      chk(fixed, "row not repaired");
      chk(seen === t, "wrong target");
      chk(t_pre - t_wra >= PGM, "precharge early");
      chk(t_clr - t_pre >= EXT, "exit early");
      chk(t_mr0 - t_clr >= PST, "restore early");
      chk(t_mr0 > t_clr, "mode not restored");
   endtask : run_repair
   task sc_plain;
      run_repair({2'h3, 2'h3, 18'h3FFFF}, 1'b0);
      chk(refs === 8'h00, "refresh unasked");
   endtask : sc_plain
   // Second row with refresh wanted all along: gaps allow two or three in the wait.
   task sc_refresh;
      run_repair({2'h0, 2'h1, 18'h00000}, 1'b1);
      chk(refs >= 8'h02 && refs <= 8'h03, "refresh count");
   endtask : sc_refresh
   task complete_run;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (5) @(negedge i_clk);
      i_resetn = 1'b1;
      sc_plain();
      sc_refresh();
      complete_run();
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
